// *** legacy_decode_regs.svh ***
`ifndef LEGACY_DECODE_REGS_SVH
`define LEGACY_DECODE_REGS_SVH

// register offsets and reset values
`define ATTR_FIRST_OFS  8'h59
`define ATTR_LAST_OFS   8'h5F
`define SMM_CTRL_OFS    8'h70
`define SMM_CTRL_RESET  8'h00
`define ATTR_RESET      2'h0

// control register field positions
`define GMS_MSB         7
`define GMS_LSB         6
`define UPPER_SMM_SELECT_MSB        5
`define UPPER_SMM_SELECT_LSB        4
`define LOWER_SMM_SELECT_MSB        3
`define LOWER_SMM_SELECT_LSB        2
`define LOCK_BIT        1
`define ERR_BIT         0

// attribute nibble bits
`define ATTR_RE_BIT     0
`define ATTR_WE_BIT     1

// segment layout below 1 MB
`define SEG_COUNT       12
`define BIOS_SEG        4'hC
`define VGA_PAGE        3'h5
`define EXP_PAGE        2'h3
`define BIOS_PAGE       4'hF
`define DOS_LIMIT       20'hA0000

// carve sizes
`define SIZE_NONE       32'h0000_0000
`define SIZE_512K       32'h0008_0000
`define SIZE_1M         32'h0010_0000

`endif

// *** legacy_decode_pkg.sv ***
package legacy_decode_pkg;

    // graphics memory select encodings
    typedef enum logic [1:0]
    {
        GFX_OFF    = 2'h0,
        GFX_NO_MEM = 2'h1,
        GFX_512K   = 2'h2,
        GFX_1M     = 2'h3
    } gfx_sel_e;

    // where a legacy cycle is sent
    typedef enum logic [1:0]
    {
        ROUTE_HUB  = 2'h0,
        ROUTE_DRAM = 2'h1,
        ROUTE_GFX  = 2'h3
    } route_e;

    // write/read enable pair of one segment
    typedef logic [1:0] seg_attr_t;

endpackage

// *** legacy_segment_decode.sv ***
`include "legacy_decode_regs.svh"

module legacy_segment_decode
(
    // cycle
    input  wire logic [19:0] addr_i,
    input  wire logic        write_i,
    // attribute pairs, system bios pair in the top two bits
    input  wire logic [25:0] attr_i,
    // decode result
    output logic             seg_hit_o,
    output logic             seg_dram_o
);
    import legacy_decode_pkg::*;

    // segment number of an address in C0000h-FFFFFh
    function automatic logic [3:0] seg_index(input logic [19:0] a);
        if (a[19:16] == `BIOS_PAGE)
        begin
            seg_index = `BIOS_SEG;
        end
        else
        begin
            seg_index = a[17:14];
        end
    endfunction

    seg_attr_t attr_sel;

    // pick the pair and steer reads and writes by their own enable
    always_comb
    begin
        attr_sel   = attr_i[{seg_index(addr_i), 1'b0} +: 2];
        seg_hit_o  = (addr_i[19:18] == `EXP_PAGE);
        seg_dram_o = seg_hit_o &&
                     (write_i ? attr_sel[`ATTR_WE_BIT]
                              : attr_sel[`ATTR_RE_BIT]);
    end

endmodule

// *** gfx_memory_carve.sv ***
`include "legacy_decode_regs.svh"

module gfx_memory_carve
(
    // configuration
    input  wire logic [31:0]                  tom_i,
    input  wire logic [1:0]                   upper_smm_select_i,
    input  legacy_decode_pkg::gfx_sel_e       gms_i,
    input  wire logic                         agp_mode_i,
    // carve result
    output logic [31:0]                       top_smm_segment_base_o,
    output logic [31:0]                       gfx_base_o,
    output logic                              gfx_enable_o
);
    import legacy_decode_pkg::*;

    logic [31:0] top_smm_segment_size;
    logic [31:0] gfx_size;

    // top segment is taken first, graphics memory below it
    always_comb
    begin
        case (upper_smm_select_i)
            2'h2:    top_smm_segment_size = `SIZE_512K;
            2'h3:    top_smm_segment_size = `SIZE_1M;
            default: top_smm_segment_size = `SIZE_NONE;
        endcase
        gfx_enable_o = !agp_mode_i && (gms_i != GFX_OFF);
        case (gms_i)
            GFX_512K: gfx_size = `SIZE_512K;
            GFX_1M:   gfx_size = `SIZE_1M;
            default:  gfx_size = `SIZE_NONE;
        endcase
        if (!gfx_enable_o)
        begin
            gfx_size = `SIZE_NONE;
        end
        top_smm_segment_base_o = tom_i - top_smm_segment_size;
        gfx_base_o  = top_smm_segment_base_o - gfx_size;
    end

endmodule

// *** legacy_region_smm_graphics_memory_control_decode.sv ***
// Decided for this implementation: strobed register access.
`include "legacy_decode_regs.svh"

module legacy_region_smm_graphics_memory_control_decode
(
    // clock and reset
    input  wire logic                   clk_i,
    input  wire logic                   reset_n_i,
    // register port
    input  wire logic [7:0]             reg_addr_i,
    input  wire logic [7:0]             reg_wdata_i,
    input  wire logic                   reg_wr_i,
    input  wire logic                   reg_rd_i,
    output logic      [7:0]             reg_rdata_o,
    // processor cycle
    input  wire logic                   cyc_valid_i,
    input  wire logic [31:0]            cyc_addr_i,
    input  wire logic                   cyc_write_i,
    input  wire logic                   cyc_smm_i,
    // system state
    input  wire logic                   agp_mode_i,
    input  wire logic [31:0]            tom_i,
    input  wire logic                   smm_error_i,
    // routing result
    output logic                        route_valid_o,
    output logic      [31:0]            route_addr_o,
    output logic                        route_write_o,
    output logic                        route_dram_o,
    output logic                        route_hub_o,
    output logic                        route_gfx_o,
    output logic                        route_claim_o,
    // graphics and smm configuration
    output logic                        gfx_enable_o,
    output logic                        gfx_clock_en_o,
    output legacy_decode_pkg::gfx_sel_e gfx_select_o,
    output logic      [1:0]             upper_smm_select_o,
    output logic      [1:0]             lower_smm_select_o,
    output logic                        smm_space_lock_o,
    output logic      [31:0]            top_smm_segment_base_o,
    output logic      [31:0]            gfx_base_o
);
    import legacy_decode_pkg::*;

    seg_attr_t   attr_r [0:`SEG_COUNT-1];
    seg_attr_t   bios_attr_r;
    gfx_sel_e    gms_r;
    logic [1:0]  upper_smm_select_r;
    logic [1:0]  lower_smm_select_r;
    logic        lock_r;
    logic        err_r;
    logic [25:0] attr_flat;
    logic        seg_hit;
    logic        seg_dram;
    logic [31:0] top_smm_segment_base_nxt;
    logic [31:0] gfx_base_nxt;
    logic        gfx_en_nxt;
    logic        ctrl_wr;
    logic        legacy_hit;
    logic        is_vga;
    route_e      route_nxt;

    // register write strobes
    assign ctrl_wr = reg_wr_i && (reg_addr_i == `SMM_CTRL_OFS);

    // attribute byte as software sees it, reserved bits zero
    function automatic logic [7:0] attr_byte(input logic [7:0] ofs);
        logic [3:0] lo;
        lo = 4'(({ofs[3:0], 1'b0}) - 5'h14);
        attr_byte = 8'h00;
        if (ofs == `ATTR_FIRST_OFS)
        begin
            attr_byte = {2'h0, bios_attr_r, 4'h0};
        end
        else if (ofs > `ATTR_FIRST_OFS && ofs <= `ATTR_LAST_OFS)
        begin
            attr_byte = {2'h0, attr_r[lo + 4'h1], 2'h0, attr_r[lo]};
        end
    endfunction

    // one attribute pair per 16 KB segment, two per register
    genvar s;
    generate
        for (s = 0; s < `SEG_COUNT; s = s + 1)
        begin : g_seg
            localparam logic [7:0] SEG_OFS = 8'(`ATTR_FIRST_OFS + 1 + s / 2);
            localparam int         SEG_LSB = (s % 2) * 4;

            // segments C0000h-DFFFFh and E0000h-EFFFFh
            always_ff @(posedge clk_i)
            begin
                if (!reset_n_i)
                begin
                    attr_r[s] <= `ATTR_RESET;
                end
                else if (reg_wr_i && reg_addr_i == SEG_OFS)
                begin
                    attr_r[s] <= reg_wdata_i[SEG_LSB +: 2];
                end
            end
        end
    endgenerate

    // system bios pair in the upper nibble of the first register
    always_ff @(posedge clk_i)
    begin
        if (!reset_n_i)
        begin
            bios_attr_r <= `ATTR_RESET;
        end
        else if (reg_wr_i && reg_addr_i == `ATTR_FIRST_OFS)
        begin
            bios_attr_r <= reg_wdata_i[5:4];
        end
    end

    // graphics select, frozen by the lock
    always_ff @(posedge clk_i)
    begin
        if (!reset_n_i)
        begin
            gms_r <= GFX_OFF;
        end
        else if (ctrl_wr && !lock_r)
        begin
            gms_r <= gfx_sel_e'(reg_wdata_i[`GMS_MSB:`GMS_LSB]);
        end
    end

    // upper smm select, also frozen by the lock
    always_ff @(posedge clk_i)
    begin
        if (!reset_n_i)
        begin
            upper_smm_select_r <= 2'h0;
        end
        else if (ctrl_wr && !lock_r)
        begin
            upper_smm_select_r <= reg_wdata_i[`UPPER_SMM_SELECT_MSB:`UPPER_SMM_SELECT_LSB];
        end
    end

    // lower smm select
    always_ff @(posedge clk_i)
    begin
        if (!reset_n_i)
        begin
            lower_smm_select_r <= 2'h0;
        end
        else if (ctrl_wr)
        begin
            lower_smm_select_r <= reg_wdata_i[`LOWER_SMM_SELECT_MSB:`LOWER_SMM_SELECT_LSB];
        end
    end

    // lock only sets; reset is the sole way out
    always_ff @(posedge clk_i)
    begin
        if (!reset_n_i)
        begin
            lock_r <= 1'b0;
        end
        else if (ctrl_wr && reg_wdata_i[`LOCK_BIT])
        begin
            lock_r <= 1'b1;
        end
    end

    // error flag: hardware set beats a write-one clear
    always_ff @(posedge clk_i)
    begin
        if (!reset_n_i)
        begin
            err_r <= 1'b0;
        end
        else if (smm_error_i)
        begin
            err_r <= 1'b1;
        end
        else if (ctrl_wr && reg_wdata_i[`ERR_BIT])
        begin
            err_r <= 1'b0;
        end
    end

    // read data valid only in the cycle after the strobe
    always_ff @(posedge clk_i)
    begin
        if (!reset_n_i || !reg_rd_i)
        begin
            reg_rdata_o <= 8'h00;
        end
        else if (reg_addr_i == `SMM_CTRL_OFS)
        begin
            reg_rdata_o <= {gms_r, upper_smm_select_r, lower_smm_select_r, lock_r, err_r};
        end
        else
        begin
            reg_rdata_o <= attr_byte(reg_addr_i);
        end
    end

    // flatten pairs for the segment decoder
    always_comb
    begin
        attr_flat = {bios_attr_r, 24'h0};
        for (int i = 0; i < `SEG_COUNT; i++)
        begin
            attr_flat[2 * i +: 2] = attr_r[i];
        end
    end

    legacy_segment_decode u_seg
    (
        .addr_i     (cyc_addr_i[19:0]),
        .write_i    (cyc_write_i),
        .attr_i     (attr_flat),
        .seg_hit_o  (seg_hit),
        .seg_dram_o (seg_dram)
    );

    gfx_memory_carve u_carve
    (
        .tom_i        (tom_i),
        .upper_smm_select_i       (upper_smm_select_r),
        .gms_i        (gms_r),
        .agp_mode_i   (agp_mode_i), // only read, never written here
        .top_smm_segment_base_o  (top_smm_segment_base_nxt),
        .gfx_base_o   (gfx_base_nxt),
        .gfx_enable_o (gfx_en_nxt)
    );

    // pick a destination for the cycle below 1 MB
    assign legacy_hit = (cyc_addr_i[31:20] == 12'h000);
    assign is_vga     = (cyc_addr_i[19:17] == `VGA_PAGE);

    always_comb
    begin
        route_nxt = ROUTE_HUB;
        if (cyc_addr_i[19:0] < `DOS_LIMIT)
        begin
            route_nxt = ROUTE_DRAM;
        end
        else if (is_vga)
        begin
            if (gfx_en_nxt && !cyc_smm_i)
            begin
                route_nxt = ROUTE_GFX;
            end
            else
            begin
                route_nxt = ROUTE_HUB;
            end
        end
        else if (seg_hit && seg_dram)
        begin
            route_nxt = ROUTE_DRAM;
        end
        else
        begin
            route_nxt = ROUTE_HUB; // unclaimed, left subtractive
        end
    end

    // registered routing result, address passed through untouched
    always_ff @(posedge clk_i)
    begin
        if (!reset_n_i)
        begin
            route_valid_o <= 1'b0;
            route_addr_o  <= 32'h0000_0000;
            route_write_o <= 1'b0;
            route_dram_o  <= 1'b0;
            route_hub_o   <= 1'b0;
            route_gfx_o   <= 1'b0;
            route_claim_o <= 1'b0;
        end
        else
        begin
            route_valid_o <= cyc_valid_i && legacy_hit;
            route_addr_o  <= cyc_addr_i;
            route_write_o <= cyc_write_i;
            route_dram_o  <= cyc_valid_i && legacy_hit && route_nxt == ROUTE_DRAM;
            route_hub_o   <= cyc_valid_i && legacy_hit && route_nxt == ROUTE_HUB;
            route_gfx_o   <= cyc_valid_i && legacy_hit && route_nxt == ROUTE_GFX;
            route_claim_o <= cyc_valid_i && legacy_hit && route_nxt != ROUTE_HUB;
        end
    end

    // registered configuration view
    always_ff @(posedge clk_i)
    begin
        if (!reset_n_i)
        begin
            gfx_enable_o   <= 1'b0;
            gfx_clock_en_o <= 1'b0;
            top_smm_segment_base_o    <= 32'h0000_0000;
            gfx_base_o     <= 32'h0000_0000;
        end
        else
        begin
            gfx_enable_o   <= gfx_en_nxt;
            gfx_clock_en_o <= gfx_en_nxt; // clocks off when disabled
            top_smm_segment_base_o    <= top_smm_segment_base_nxt;
            gfx_base_o     <= gfx_base_nxt;
        end
    end

    assign gfx_select_o       = gms_r;
    assign upper_smm_select_o = upper_smm_select_r;
    assign lower_smm_select_o = lower_smm_select_r;
    assign smm_space_lock_o   = lock_r;

    // checks on the routing and the control register
    a_bios_default_hub: assert property (
        @(posedge clk_i) disable iff (!reset_n_i)
        cyc_valid_i && legacy_hit && cyc_addr_i[19:16] == `BIOS_PAGE
            && bios_attr_r == 2'h0
        |=> route_hub_o && !route_claim_o && !route_dram_o)
        else $error("bios cycle with attributes clear not sent to hub");

    a_exp_disabled_sub: assert property (
        @(posedge clk_i) disable iff (!reset_n_i)
        cyc_valid_i && legacy_hit && cyc_addr_i[19:17] == 3'h6
            && attr_r[cyc_addr_i[16:14]] == 2'h0
        |=> route_hub_o && !route_claim_o)
        else $error("disabled expansion segment was claimed");

    a_addr_not_remapped: assert property (
        @(posedge clk_i) disable iff (!reset_n_i)
        cyc_valid_i && legacy_hit
        |=> route_valid_o && route_addr_o == $past(cyc_addr_i))
        else $error("legacy cycle address changed on its way out");

    a_attr_steer_read: assert property (
        @(posedge clk_i) disable iff (!reset_n_i)
        cyc_valid_i && legacy_hit && cyc_addr_i[19:16] == `BIOS_PAGE
            && !cyc_write_i && bios_attr_r[`ATTR_RE_BIT]
        |=> route_dram_o && !route_hub_o)
        else $error("read with read enable set not sent to dram");

    a_attr_steer_write: assert property (
        @(posedge clk_i) disable iff (!reset_n_i)
        cyc_valid_i && legacy_hit && cyc_addr_i[19:16] == 4'hE
            && cyc_write_i && attr_r[cyc_addr_i[17:14]] == 2'h1
        |=> route_hub_o && !route_dram_o)
        else $error("write to read-only extended segment reached dram");

    a_gms_locked: assert property (
        @(posedge clk_i) disable iff (!reset_n_i)
        lock_r && ctrl_wr |=> $stable(gms_r) && $stable(upper_smm_select_r))
        else $error("graphics select changed while locked");

    a_lock_sticky: assert property (
        @(posedge clk_i) disable iff (!reset_n_i)
        lock_r |=> lock_r [*3])
        else $error("space lock cleared without reset");

    a_vga_off_hub: assert property (
        @(posedge clk_i) disable iff (!reset_n_i)
        cyc_valid_i && legacy_hit && is_vga && gms_r == GFX_OFF
        |=> route_hub_o && !route_gfx_o && !gfx_clock_en_o)
        else $error("vga cycle not sent to hub with graphics off");

    a_vga_internal: assert property (
        @(posedge clk_i) disable iff (!reset_n_i)
        cyc_valid_i && legacy_hit && is_vga && !cyc_smm_i
            && !agp_mode_i && gms_r != GFX_OFF
        |=> route_gfx_o && route_claim_o)
        else $error("non-smm vga cycle not served internally");

    a_agp_ignores_gms: assert property (
        @(posedge clk_i) disable iff (!reset_n_i)
        agp_mode_i |=> !gfx_enable_o && gfx_base_o == top_smm_segment_base_o)
        else $error("graphics select took effect in agp mode");

    a_gfx_below_top_smm_segment: assert property (
        @(posedge clk_i) disable iff (!reset_n_i)
        !agp_mode_i && gms_r == GFX_1M && upper_smm_select_r == 2'h3
        |=> gfx_base_o == tom_i - 32'h0020_0000)
        else $error("graphics memory not carved below top smm segment");

    a_gms_decode_512k: assert property (
        @(posedge clk_i) disable iff (!reset_n_i)
        !agp_mode_i && gms_r == GFX_512K
        |=> top_smm_segment_base_o - gfx_base_o == 32'h0008_0000)
        else $error("512 KB select did not reserve 512 KB");

    a_read_one_cycle: assert property (
        @(posedge clk_i) disable iff (!reset_n_i)
        reg_rd_i && reg_addr_i == `SMM_CTRL_OFS
        |=> reg_rdata_o == {gms_r, upper_smm_select_r, lower_smm_select_r, lock_r, $past(err_r)} ##1 reg_rdata_o == 8'h00
            || $past(reg_rd_i))
        else $error("control register read data wrong or held too long");

endmodule

// *** far_side_model.sv ***
// sink standing for dram, hub interface and graphics behind the decoder
module far_side_model
(
    // clock
    input  wire logic        clk_i,
    // routed cycle
    input  wire logic        route_valid_i,
    input  wire logic        route_dram_i,
    input  wire logic        route_hub_i,
    input  wire logic        route_gfx_i,
    input  wire logic        route_claim_i,
    // faults seen
    output int               n_bad_o
);
    timeunit 1ns;
    timeprecision 1ps;

    initial n_bad_o = 0;

    // each routed cycle lands on exactly one target; only dram and gfx claim it
    always @(posedge clk_i)
    begin
        if (route_valid_i === 1'b1)
        begin
            if ((route_dram_i + route_hub_i + route_gfx_i) != 2'd1)
                n_bad_o <= n_bad_o + 1;
            if (route_claim_i !== (route_dram_i | route_gfx_i))
                n_bad_o <= n_bad_o + 1;
        end
    end
endmodule

// *** tb_legacy_region_smm_graphics_memory_control_decode.sv ***
module tb_legacy_region_smm_graphics_memory_control_decode;
    timeunit 1ns;
    timeprecision 1ps;
    import legacy_decode_pkg::*;

    logic clk_i = 0, reset_n_i = 0, reg_wr_i = 0, reg_rd_i = 0, cyc_valid_i = 0;
    logic cyc_write_i = 0, cyc_smm_i = 0, agp_mode_i = 0, smm_error_i = 0;
    logic [7:0] reg_addr_i = 8'h00, reg_wdata_i = 8'h00, reg_rdata_o;
    logic [31:0] cyc_addr_i = 32'h0, tom_i = 32'h0400_0000, route_addr_o;
    logic [31:0] top_smm_segment_base_o, gfx_base_o;
    logic route_valid_o, route_write_o, route_dram_o, route_hub_o, route_gfx_o;
    logic route_claim_o, gfx_enable_o, gfx_clock_en_o, smm_space_lock_o;
    logic [1:0] upper_smm_select_o, lower_smm_select_o;
    gfx_sel_e gfx_select_o;
    int n_errors = 0, checks_done = 0, n_bad;
    localparam logic [2:0] D = 3'h4, H = 3'h2, G = 3'h1, N = 3'h0;

    legacy_region_smm_graphics_memory_control_decode dut (.clk_i(clk_i), .reset_n_i(reset_n_i),
        .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
        .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .cyc_valid_i(cyc_valid_i),
        .cyc_addr_i(cyc_addr_i), .cyc_write_i(cyc_write_i), .cyc_smm_i(cyc_smm_i),
        .agp_mode_i(agp_mode_i), .tom_i(tom_i), .smm_error_i(smm_error_i),
        .route_valid_o(route_valid_o), .route_addr_o(route_addr_o),
        .route_write_o(route_write_o), .route_dram_o(route_dram_o),
        .route_hub_o(route_hub_o), .route_gfx_o(route_gfx_o),
        .route_claim_o(route_claim_o), .gfx_enable_o(gfx_enable_o),
        .gfx_clock_en_o(gfx_clock_en_o), .gfx_select_o(gfx_select_o),
        .upper_smm_select_o(upper_smm_select_o),
        .lower_smm_select_o(lower_smm_select_o), .smm_space_lock_o(smm_space_lock_o),
        .top_smm_segment_base_o(top_smm_segment_base_o), .gfx_base_o(gfx_base_o));

    far_side_model far (.clk_i(clk_i), .route_valid_i(route_valid_o),
        .route_dram_i(route_dram_o), .route_hub_i(route_hub_o), .route_gfx_i(route_gfx_o),
        .route_claim_i(route_claim_o), .n_bad_o(n_bad));

    // 50 MHz clock
    always #10 clk_i = ~clk_i;

    // value comparison
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e)
        begin
            $display("mismatch %s expected %h seen %h", n, e, g);
            n_errors++;
        end
    endtask

    // register bus write and read
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge clk_i);
        reg_wr_i <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e, input string n);
        @(posedge clk_i);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge clk_i);
        reg_rd_i <= 1'b0;
        #1 chk(n, {24'h0, e}, {24'h0, reg_rdata_o});
    endtask

    // one processor cycle; t is the expected {dram, hub, gfx}, N for none
    task automatic cyc(input logic [31:0] a, input logic w, input logic s,
                       input logic [2:0] t);
        @(posedge clk_i);
        cyc_valid_i <= 1'b1;
        cyc_addr_i <= a;
        cyc_write_i <= w;
        cyc_smm_i <= s;
        @(posedge clk_i);
        cyc_valid_i <= 1'b0;
        #1 chk("route_valid", {31'h0, t != N}, {31'h0, route_valid_o});
        if (t != N)
        begin
            chk("route_target", {29'h0, t}, {29'h0, route_dram_o, route_hub_o, route_gfx_o});
            chk("route_addr", a, route_addr_o);
            chk("route_write", {31'h0, w}, {31'h0, route_write_o});
        end
    endtask

    task automatic do_reset();
        @(posedge clk_i);
        reset_n_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        reset_n_i <= 1'b1;
    endtask

    // reset defaults, disabled segments and the fixed areas
    task automatic t_defaults();
        rd(8'h70, 8'h00, "ctrl_reset");
        rd(8'h59, 8'h00, "attr_reset");
        cyc(32'hF8000, 1'b0, 1'b0, H);
        cyc(32'hF0000, 1'b1, 1'b0, H);
        cyc(32'hC4000, 1'b0, 1'b0, H);
        cyc(32'hE8000, 1'b1, 1'b0, H);
        cyc(32'h9FFFF, 1'b0, 1'b0, D);
        cyc(32'h100000, 1'b0, 1'b0, N);
        wr(8'h80, 8'hFF);
        rd(8'h80, 8'h00, "unmapped");
    endtask

    // per segment steering: low nibble read-only, high nibble write-only
    task automatic t_segments();
        logic [31:0] a;
        for (int r = 0; r < 6; r++)
            wr(8'h5A + r[7:0], 8'h21);
        rd(8'h5F, 8'h21, "attr_5f");
        for (int k = 0; k < 12; k++)
        begin
            a = 32'hC0000 + k * 32'h4000;
            cyc(a, 1'b0, 1'b0, k[0] ? H : D);
            cyc(a + 32'h3FFF, 1'b1, 1'b0, k[0] ? D : H);
        end
        wr(8'h5A, 8'hFF);
        rd(8'h5A, 8'h33, "attr_reserved");
        wr(8'h59, 8'hFF);
        rd(8'h59, 8'h30, "attr_59_reserved");
        cyc(32'hFFFFF, 1'b0, 1'b0, D);
    endtask

    // bios shadowing: write-only copy, then read-only
    task automatic t_shadow();
        wr(8'h59, 8'h20);
        cyc(32'hF1000, 1'b0, 1'b0, H);
        cyc(32'hF1000, 1'b1, 1'b0, D);
        wr(8'h59, 8'h10);
        cyc(32'hF1000, 1'b0, 1'b0, D);
        cyc(32'hF1000, 1'b1, 1'b0, H);
    endtask

    // every graphics select code, top smm segment of 512 KB (u=10) or 1 MB (u=11)
    task automatic t_gfx(input logic agp, input logic [1:0] u);
        logic [31:0] tb, sz;
        @(posedge clk_i);
        agp_mode_i <= agp;
        tb = tom_i - (u == 2'h3 ? 32'h0010_0000 : 32'h0008_0000);
        for (int g = 0; g < 4; g++)
        begin
            sz = (agp || g < 2) ? 32'h0 : (g == 2 ? 32'h0008_0000 : 32'h0010_0000);
            wr(8'h70, {g[1:0], u, 4'h0});
            repeat (2) @(posedge clk_i);
            #1 chk("gfx_enable", {31'h0, !agp && g != 0}, {31'h0, gfx_enable_o});
            chk("gfx_clock", {31'h0, !agp && g != 0}, {31'h0, gfx_clock_en_o});
            chk("top_smm_segment_base", tb, top_smm_segment_base_o);
            chk("gfx_base", tb - sz, gfx_base_o);
            if (g != 1)
                cyc(32'hB8000, 1'b0, 1'b0, (!agp && g != 0) ? G : H);
            cyc(32'hA0000, 1'b1, 1'b1, H);
        end
        @(posedge clk_i);
        agp_mode_i <= 1'b0;
    endtask

    // error flag, lock and its release by reset only
    task automatic t_lock();
        @(posedge clk_i);
        smm_error_i <= 1'b1;
        @(posedge clk_i);
        smm_error_i <= 1'b0;
        rd(8'h70, 8'hE1, "error_set");
        wr(8'h70, 8'hE1);
        rd(8'h70, 8'hE0, "error_clear");
        wr(8'h70, 8'hE2);
        rd(8'h70, 8'hE2, "lock_set");
        wr(8'h70, 8'h04);
        rd(8'h70, 8'hE6, "locked_write");
        chk("lock_out", 32'h1, {31'h0, smm_space_lock_o});
        chk("gfx_select", 32'h3, {30'h0, gfx_select_o});
        chk("upper_smm", 32'h2, {30'h0, upper_smm_select_o});
        chk("lower_smm", 32'h1, {30'h0, lower_smm_select_o});
        do_reset();
        rd(8'h70, 8'h00, "lock_reset");
    endtask

    task automatic give_verdict();
        chk("far_side_faults", 32'h0, n_bad);
        if (n_errors == 0 && checks_done > 0 && n_bad == 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // watchdog
    initial
    begin
        #200000;
        n_errors++;
        give_verdict();
    end

    // main sequence
    initial
    begin
        repeat (3) @(posedge clk_i);
        reset_n_i <= 1'b1;
        t_defaults();
        t_segments();
        t_shadow();
        t_gfx(1'b0, 2'h2);
        t_gfx(1'b0, 2'h3);
        t_gfx(1'b1, 2'h2);
        t_lock();
        give_verdict();
    end
endmodule
